// ==== include/sbs_pkg.sv ====
// sbs_pkg: constants and types of the burst sram control block
// How it works
// R1 - interleaved burst: low bits are start XOR step
// R2 - linear burst: low bits are start plus step
// R3 - three continues at most; fourth wraps to base
// R4 - two true and two inverted echo clocks
// R5 - bank deselect floats echo clocks, data delay
// R6 - primary enable deselect keeps echo clocks running
// R7 - bank enables must match their polarity straps
// R8 - deselects and writes float data one cycle later
// R9 - only bank deselect floats the echo clocks
// R10 - write stores only lanes whose strobe is low
// R11 - write with advance low loads new address
// R12 - continue steps address, repeats previous operation
// R13 - write continue without strobes stores nothing
// R14 - primary deselect floats data, echo keeps running
// R15 - next state from enables, advance, write enable
// R16 - system straps polarities for four banks
// R17 - controller pauses at bank switch for echo
// R18 - read data appears after next rising edge
// R19 - write data arrives on third rising edge
// R20 - advance low loads, high continues burst
// R21 - inverted echo clocks exactly complement true ones
package sbs_pkg;
    localparam int ADDR_W = 19;
    localparam int LANES = 4;
    localparam int LANE_W = 9;
    localparam int BURST_W = 2;
    localparam int WQ_DEPTH = 16;
    // link edges from a write command to the edge that carries its data
    localparam int WR_LAT = 2;
    localparam logic [BURST_W-1:0] STEP_ONE = 2'h1;
    localparam logic [BURST_W-1:0] STEP_LAST = 2'h3;
    localparam logic [BURST_W-1:0] RST_STEP = 2'h0;
    localparam logic RST_DQ_OE = 1'h0;
    localparam logic RST_ECHO_OE = 1'h1;
    localparam logic RST_ECHO_INV = 1'h1;

    typedef enum logic [1:0] {
        SBS_DESEL,
        SBS_BANK_DESEL,
        SBS_READ,
        SBS_WRITE
    } sbs_op_t;

    localparam sbs_op_t RST_OP = SBS_DESEL;
endpackage : sbs_pkg

// ==== rtl/sbs_sram_ctrl.sv ====
// sbs_sram_ctrl: write queue and control logic of the burst sram
`timescale 1ns/1ps

// ----------------------------------------
// write queue
// ----------------------------------------
module sbs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [PW:0] cnt;
    } sbs_fifo_state_t;

    sbs_fifo_state_t st;
    sbs_fifo_state_t next_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
        $error("sbs_fifo: DEPTH must be a power of two, at least 2");
    end

    assign o_in_ready = (st.cnt != (PW + 1)'(DEPTH));
    assign o_out_valid = (st.cnt != '0);
    assign o_out_data = mem[st.rp];
    assign push = i_in_valid && o_in_ready;
    assign pop = i_out_ready && o_out_valid;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.wp = PW'(st.wp + 1'b1);
        end
        if (pop) begin
            next_st.rp = PW'(st.rp + 1'b1);
        end
        next_st.cnt = st.cnt + (PW + 1)'(push) - (PW + 1)'(pop);
    end

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[st.wp] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule : sbs_fifo

// ----------------------------------------
// sram control
// ----------------------------------------
module sbs_sram_ctrl #(
    parameter int ADDR_W = sbs_pkg::ADDR_W,
    parameter int LANE_W = sbs_pkg::LANE_W,
    parameter int WQ_DEPTH = sbs_pkg::WQ_DEPTH
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_link_clk,
    input wire logic i_primary_chip_enable_n,
    input wire logic i_bank_enable_a,
    input wire logic i_bank_enable_b,
    input wire logic i_bank_enable_a_polarity,
    input wire logic i_bank_enable_b_polarity,
    input wire logic i_burst_order_select_n,
    input wire logic i_address_advance,
    input wire logic i_write_enable_n,
    input wire logic i_byte_write_lane0_n,
    input wire logic i_byte_write_lane1_n,
    input wire logic i_byte_write_lane2_n,
    input wire logic i_byte_write_lane3_n,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [sbs_pkg::LANES*LANE_W-1:0] i_dq,
    output logic [sbs_pkg::LANES*LANE_W-1:0] o_dq,
    output logic o_dq_oe,
    output logic o_echo_clock_true_0,
    output logic o_echo_clock_true_1,
    output logic o_echo_clock_inv_0,
    output logic o_echo_clock_inv_1,
    output logic o_echo_oe
);
    localparam int LANES = sbs_pkg::LANES;
    localparam int DW = LANES * LANE_W;
    localparam int QW = ADDR_W + LANES;
    localparam int LAT = sbs_pkg::WR_LAT;

    if (ADDR_W < 3 || ADDR_W > 24 || LANE_W < 1 || WQ_DEPTH <= LAT) begin : g_bad_par
        $error("sbs_sram_ctrl: unsupported parameter values");
    end

    typedef struct packed {
        logic lclk;
        logic pce_n;
        logic bank_a;
        logic bank_b;
        logic pol_a;
        logic pol_b;
        logic order_n;
        logic advance;
        logic wen_n;
        logic [LANES-1:0] lane_n;
        logic [ADDR_W-1:0] addr;
        logic [DW-1:0] dq;
    } sbs_pins_t;

    typedef struct packed {
        sbs_pins_t s1;
        sbs_pins_t s2;
        sbs_pkg::sbs_op_t op;
        logic [ADDR_W-1:0] base;
        logic [sbs_pkg::BURST_W-1:0] step;
        logic [LAT-1:0] wr_pipe;
        logic [DW-1:0] dq_out;
        logic dq_oe;
        logic echo_t;
        logic echo_i;
        logic echo_oe;
    } sbs_state_t;

    sbs_state_t st;
    sbs_state_t next_st;
    sbs_pins_t pins;
    logic [DW-1:0] mem [2**ADDR_W];
    logic rise;
    logic match;
    logic rw_op;
    logic [ADDR_W-1:0] cur_addr;
    logic [DW-1:0] rd_word;
    logic q_push;
    logic q_ready;
    logic q_valid;
    logic q_pop;
    logic [QW-1:0] q_in;
    logic [QW-1:0] q_out;
    logic mem_we;

    function automatic logic [ADDR_W-1:0] burst_addr(
        input logic [ADDR_W-1:0] base,
        input logic [1:0] step,
        input logic interleave
    );
        logic [1:0] low;
        low = interleave ? (base[1:0] ^ step) : 2'(base[1:0] + step); // see R1 R2
        return {base[ADDR_W-1:2], low};
    endfunction : burst_addr

    assign pins = '{
        lclk: i_link_clk,
        pce_n: i_primary_chip_enable_n,
        bank_a: i_bank_enable_a,
        bank_b: i_bank_enable_b,
        pol_a: i_bank_enable_a_polarity,
        pol_b: i_bank_enable_b_polarity,
        order_n: i_burst_order_select_n,
        advance: i_address_advance,
        wen_n: i_write_enable_n,
        lane_n: {i_byte_write_lane3_n, i_byte_write_lane2_n,
                 i_byte_write_lane1_n, i_byte_write_lane0_n},
        addr: i_addr,
        dq: i_dq
    };

    // echo_t holds the previous synchronised link clock level
    assign rise = st.s2.lclk && !st.echo_t;
    assign match = (st.s2.bank_a == st.s2.pol_a) && (st.s2.bank_b == st.s2.pol_b); // see R7
    assign rw_op = (st.op == sbs_pkg::SBS_READ) || (st.op == sbs_pkg::SBS_WRITE);
    assign cur_addr = burst_addr(st.base, st.step, st.s2.order_n);
    assign rd_word = mem[cur_addr];
    // data for a queued write is on the pins at the third link edge
    assign q_pop = rise && st.wr_pipe[LAT-1]; // see R19
    assign mem_we = q_pop && q_valid;

    // ----------------------------------------
    // command decode and burst counter
    // ----------------------------------------
    always_comb begin
        next_st = st;
        next_st.s1 = pins;
        next_st.s2 = st.s1;
        next_st.echo_t = st.s2.lclk; // see R4
        next_st.echo_i = !st.s2.lclk; // see R21
        q_push = 1'h0;
        q_in = '0;
        if (rise) begin
            // pins follow the operation sampled one link edge earlier
            next_st.dq_oe = (st.op == sbs_pkg::SBS_READ); // see R8 R14
            next_st.dq_out = rd_word; // see R18
            next_st.echo_oe = (st.op != sbs_pkg::SBS_BANK_DESEL); // see R5 R6 R9
            next_st.wr_pipe = {st.wr_pipe[LAT-2:0], 1'h0};
            if (!st.s2.advance) begin // see R15 R20
                if (st.s2.pce_n) begin
                    next_st.op = sbs_pkg::SBS_DESEL;
                end else if (!match) begin
                    next_st.op = sbs_pkg::SBS_BANK_DESEL;
                end else begin
                    next_st.op = st.s2.wen_n ? sbs_pkg::SBS_READ : sbs_pkg::SBS_WRITE;
                    next_st.base = st.s2.addr; // see R11
                    next_st.step = sbs_pkg::RST_STEP;
                end
            end else if (rw_op) begin
                // two-bit step wraps so a fourth continue returns to base
                next_st.step = st.step + sbs_pkg::STEP_ONE; // see R3 R12
            end
            if (next_st.op == sbs_pkg::SBS_WRITE) begin
                q_push = 1'h1;
                // an all-high strobe set queues an empty mask: address moves, nothing stored
                q_in = {burst_addr(next_st.base, next_st.step, st.s2.order_n),
                        ~st.s2.lane_n}; // see R10 R13
                next_st.wr_pipe[0] = q_ready;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st <= '0;
            st.op <= sbs_pkg::RST_OP;
            st.dq_oe <= sbs_pkg::RST_DQ_OE;
            st.echo_oe <= sbs_pkg::RST_ECHO_OE;
            st.echo_i <= sbs_pkg::RST_ECHO_INV;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // write queue and array
    // ----------------------------------------
    sbs_fifo #(
        .WIDTH(QW),
        .DEPTH(WQ_DEPTH)
    ) u_wq (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_in_valid(q_push),
        .o_in_ready(q_ready),
        .i_in_data(q_in),
        .o_out_valid(q_valid),
        .i_out_ready(q_pop),
        .o_out_data(q_out)
    );

    always_ff @(posedge i_clk) begin
        for (int g = 0; g < LANES; g++) begin
            if (mem_we && q_out[g]) begin // see R10
                mem[q_out[QW-1:LANES]][g*LANE_W +: LANE_W] <= st.s2.dq[g*LANE_W +: LANE_W];
            end
        end
    end

    assign o_dq = st.dq_out;
    assign o_dq_oe = st.dq_oe;
    assign o_echo_clock_true_0 = st.echo_t;
    assign o_echo_clock_true_1 = st.echo_t;
    assign o_echo_clock_inv_0 = st.echo_i;
    assign o_echo_clock_inv_1 = st.echo_i;
    assign o_echo_oe = st.echo_oe;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    burst_ilv_a: assert property (rw_op && st.s2.order_n |-> // see R1
        ((cur_addr[1:0] ^ st.base[1:0]) == st.step)
        && (cur_addr[ADDR_W-1:2] == st.base[ADDR_W-1:2]))
        else $error("interleaved burst address wrong");
    burst_lin_a: assert property (rw_op && !st.s2.order_n |-> // see R2
        (2'(cur_addr[1:0] - st.base[1:0]) == st.step))
        else $error("linear burst address wrong");
    burst_wrap_a: assert property (rise && st.s2.advance && rw_op // see R3
        && st.step == sbs_pkg::STEP_LAST |=> cur_addr == st.base)
        else $error("fourth continue did not wrap to base");
    cont_repeat_a: assert property (rise && st.s2.advance |=> st.op == $past(st.op)) // see R12
        else $error("continue changed the operation");
    write_load_a: assert property (rise && !st.s2.advance && !st.s2.pce_n // see R11
        && match && !st.s2.wen_n |=> st.op == sbs_pkg::SBS_WRITE && st.base == $past(st.s2.addr))
        else $error("write command did not load address");
    bank_miss_a: assert property (rise && !st.s2.advance && !st.s2.pce_n // see R7
        && ((st.s2.bank_a != st.s2.pol_a) || (st.s2.bank_b != st.s2.pol_b))
        |=> st.op == sbs_pkg::SBS_BANK_DESEL)
        else $error("bank mismatch not a bank deselect");
    dq_float_a: assert property (rise && st.op != sbs_pkg::SBS_READ |=> !o_dq_oe) // see R8
        else $error("data pins driven after non-read");
    read_data_a: assert property (rise && st.op == sbs_pkg::SBS_READ // see R18
        |=> o_dq_oe && o_dq == $past(rd_word))
        else $error("read data not presented");
    echo_keep_a: assert property (rise && st.op != sbs_pkg::SBS_BANK_DESEL |=> o_echo_oe) // see R6
        else $error("echo clocks floated without bank deselect");
    echo_off_a: assert property (rise && st.op == sbs_pkg::SBS_BANK_DESEL |=> !o_echo_oe) // see R5
        else $error("echo clocks kept on after bank deselect");
    echo_pair_a: assert property (o_echo_clock_inv_0 == !o_echo_clock_true_0 // see R21
        && o_echo_clock_inv_1 == !o_echo_clock_true_1)
        else $error("inverted echo clock not complement");
    echo_rise_a: assert property (rise |=> o_echo_clock_true_0 ##1 o_echo_clock_true_1) // see R4
        else $error("echo clock does not follow link clock");
    wr_pending_a: assert property (q_pop |-> q_valid) // see R19
        else $error("write data edge without queued write");

    read_burst_c: cover property (rise && st.s2.advance && st.op == sbs_pkg::SBS_READ
        && st.step == sbs_pkg::STEP_LAST);
    bank_off_c: cover property ($fell(o_echo_oe));
    write_abort_c: cover property (mem_we && q_out[LANES-1:0] == '0);
endmodule : sbs_sram_ctrl

// ==== sim/sbs_ctrl_model.sv ====
// sbs_ctrl_model: memory controller side that drives the link pins
`timescale 1ns/1ps
module sbs_ctrl_model #(
    parameter int AW = 8
) (
    input wire logic i_clk,
    output logic o_link_clk,
    output logic o_pce_n,
    output logic o_ea,
    output logic o_eb,
    output logic o_adv,
    output logic o_wen_n,
    output logic [3:0] o_bw_n,
    output logic [AW-1:0] o_addr,
    output logic [35:0] o_dq
);
    int slot_no = 0;
    int div = 0;
    logic run = 1'b0;
    initial begin
        o_link_clk = 1'b0;
        {o_pce_n, o_ea, o_eb, o_adv, o_wen_n, o_bw_n} = 9'h11F;
        o_addr = '0;
        o_dq = '0;
    end
    // ----
    // link clock
    // ----
    // runs free once started, like the sram clock it stands for
    always @(negedge i_clk) begin
        if (run) begin
            div = div + 1;
            if (div == 6) begin
                div = 0;
                if (o_link_clk) slot_no = slot_no + 1;
                o_link_clk = ~o_link_clk;
            end
        end
    end
    // called at the link falling edge: half a period of setup and hold
    task automatic drive(input logic [8:0] ctl, input logic [AW-1:0] a, input logic dv,
                         input logic [35:0] d);
        {o_pce_n, o_ea, o_eb, o_adv, o_wen_n, o_bw_n} = ctl;
        o_addr = a;
        // idle data lines never repeat the last word
        o_dq = dv ? d : ~o_dq;
    endtask : drive
endmodule : sbs_ctrl_model

// ==== sim/tb_sync_burst_sram_control.sv ====
// tb_sync_burst_sram_control: self-checking bench of the burst sram control
`timescale 1ns/1ps
module tb_sync_burst_sram_control;
    typedef struct {int due; logic rd; logic dq_oe; logic echo_oe; logic [35:0] dq;} sbs_exp_t;
    typedef struct {int due; logic [7:0] a; logic [3:0] m;} sbs_wr_t;
    logic i_clk, i_rstn, pa, pb, order, link, pce_n, ea, eb, address_advance, wen_n;
    logic dq_oe, t0, t1, n0, n1, echo_oe;
    logic [3:0] bw_n;
    logic [7:0] addr, base, blk, base_a;
    logic [35:0] dq_in, o_dq;
    logic [1:0] step;
    logic [35:0] mem [256];
    int last_wr [256] = '{default: -100};
    int errors = 0;
    int compares = 0;
    sbs_pkg::sbs_op_t op = sbs_pkg::SBS_DESEL;
    sbs_exp_t expq[$];
    sbs_wr_t pend[$];

    sbs_ctrl_model #(.AW(8)) mdl (.i_clk(i_clk), .o_link_clk(link), .o_pce_n(pce_n),
        .o_ea(ea), .o_eb(eb), .o_adv(address_advance), .o_wen_n(wen_n), .o_bw_n(bw_n), .o_addr(addr),
        .o_dq(dq_in));
    sbs_sram_ctrl #(.ADDR_W(8)) dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_link_clk(link),
        .i_primary_chip_enable_n(pce_n), .i_bank_enable_a(ea), .i_bank_enable_b(eb),
        .i_bank_enable_a_polarity(pa), .i_bank_enable_b_polarity(pb),
        .i_burst_order_select_n(order), .i_address_advance(address_advance), .i_write_enable_n(wen_n),
        .i_byte_write_lane0_n(bw_n[0]), .i_byte_write_lane1_n(bw_n[1]),
        .i_byte_write_lane2_n(bw_n[2]), .i_byte_write_lane3_n(bw_n[3]), .i_addr(addr),
        .i_dq(dq_in), .o_dq(o_dq), .o_dq_oe(dq_oe), .o_echo_clock_true_0(t0),
        .o_echo_clock_true_1(t1), .o_echo_clock_inv_0(n0), .o_echo_clock_inv_1(n1),
        .o_echo_oe(echo_oe));

    // ----
    // helpers
    // ----
    task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
        compares++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            errors++;
        end
    endtask : chk

    task automatic test_done();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : test_done

    // reference model of one link command, then pins driven
    task automatic cmd(input logic p, e_a, e_b, ad, w, input logic [3:0] b, input logic [7:0] a);
        sbs_exp_t x;
        logic [7:0] cur;
        logic dv;
        logic [35:0] d;
        @(negedge link);
        if (!ad) begin
            base = a;
            step = 2'h0;
            op = p ? sbs_pkg::SBS_DESEL : (e_a !== pa || e_b !== pb) ? sbs_pkg::SBS_BANK_DESEL
                : w ? sbs_pkg::SBS_READ : sbs_pkg::SBS_WRITE;
        end else step = step + 2'h1;
        cur = {base[7:2], order ? base[1:0] ^ step : base[1:0] + step};
        x.due = mdl.slot_no + 2;
        x.dq_oe = op == sbs_pkg::SBS_READ;
        x.rd = x.dq_oe && (mdl.slot_no - last_wr[cur] > 1);
        foreach (pend[i]) if (pend[i].a == cur) x.rd = 1'b0;
        x.echo_oe = op != sbs_pkg::SBS_BANK_DESEL;
        x.dq = mem[cur];
        expq.push_back(x);
        d = 36'({$urandom, $urandom});
        dv = pend.size() > 0 && pend[0].due == mdl.slot_no;
        if (dv) begin
            for (int g = 0; g < 4; g++) if (pend[0].m[g]) mem[pend[0].a][g*9 +: 9] = d[g*9 +: 9];
            last_wr[pend[0].a] = mdl.slot_no;
            void'(pend.pop_front());
        end
        if (op == sbs_pkg::SBS_WRITE && b != 4'hF) begin
            pend.push_back('{x.due, cur, ~b});
        end
        mdl.drive({p, e_a, e_b, ad, w, b}, a, dv, d);
    endtask : cmd

    // ----
    // monitors
    // ----
    always @(negedge link) begin
        if (expq.size() > 0 && expq[0].due == mdl.slot_no) begin
            chk("data enable", expq[0].dq_oe, dq_oe);
            chk("echo enable", expq[0].echo_oe, echo_oe);
            if (expq[0].rd) chk("read data", expq[0].dq, o_dq);
            void'(expq.pop_front());
        end
    end
    // looked at on a link toggle, the echo pins still show the level before it
    always @(link) if (mdl.run && echo_oe === 1'b1)
        chk("echo pins", {~link, ~link, link, link}, {t0, t1, n0, n1});

    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end
    initial begin
        #60000;
        errors++;
        test_done();
    end

    // ----
    // scenarios
    // ----
    initial begin
        void'($urandom(86944));
        i_rstn = 1'b0;
        {pa, pb, order} = 3'h5;
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
        i_rstn = 1'b1;
        chk("reset data enable", 36'h0, dq_oe);
        chk("reset echo enable", 36'h1, echo_oe);
        mdl.run = 1'b1;
        blk = 8'($urandom);
        base_a = {blk[7:2], 2'h2};
        for (int s = 0; s < 4; s++) cmd(0, pa, pb, s != 0, 0, 4'h0, base_a);
        for (int g = 0; g < 4; g++) cmd(0, pa, pb, g != 0, 0, ~(4'h1 << g), base_a);
        cmd(0, pa, pb, 0, 0, 4'hF, base_a);
        cmd(0, pa, pb, 1, 0, 4'hF, base_a);
        cmd(1, pa, pb, 0, 1, 4'h0, base_a);
        cmd(1, pa, pb, 1, 0, 4'h0, base_a);
        for (int o = 0; o < 2; o++) begin
            // order pin is static: the last burst read must leave the pipe before it moves
            repeat (2) cmd(1, pa, pb, 0, 1, 4'hF, base_a);
            order = o[0];
            for (int s = 0; s < 6; s++) begin
                cmd(0, pa, pb, s != 0, 1, 4'h0, {blk[7:2], 2'h1});
            end
        end
        for (int p = 0; p < 4; p++) begin
            cmd(1, pa, pb, 0, 1, 4'hF, base_a);
            {pa, pb} = 2'(p);
            cmd(0, pa, pb, 0, 1, 4'h0, base_a);
            cmd(0, ~pa, pb, 0, 1, 4'h0, base_a);
            cmd(0, pa, pb, 1, 0, 4'h0, base_a);
            cmd(0, pa, ~pb, 0, 0, 4'h0, base_a);
        end
        for (int i = 0; i < 40; i++)
            cmd(1'($urandom % 5 == 0), pa ^ 1'($urandom % 4 == 0), pb, 1'($urandom),
                1'($urandom), 4'($urandom), {blk[7:2], 2'($urandom)});
        repeat (3) cmd(1, pa, pb, 0, 1, 4'hF, base_a);
        for (int i = 0; i < 20 && expq.size() > 0; i++) @(negedge link);
        // a note never met by its result counts as a mismatch
        if (expq.size() > 0) errors++;
        test_done();
    end
endmodule : tb_sync_burst_sram_control
